// File: rtl/sfp_pins.sv
// Pin-level serial interface of a serial flash: shifting, line direction,
// select, pause and write-protect handling.
// Assumes a command core on clk supplies modes, transmit bytes and busy,
// and a host that owns the serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "sfp_defines.svh"

module sfp_pins (
  input  wire logic                    clk,            // System clock
  input  wire logic                    reset,          // Sync reset, high
  input  wire logic                    sclk,           // Serial clock pin
  input  wire logic                    select_n,       // Chip select, low
  input  wire logic                    pause_n,        // Pause pin, low
  input  wire logic                    write_protect_n, // Protect pin, low
  input  wire logic                    primary_data_line_in,   // Pin level
  output logic                         primary_data_line_out,  // Pin drive
  output logic                         primary_data_line_oe,   // Drive en
  input  wire logic                    secondary_data_line_in, // Pin level
  output logic                         secondary_data_line_out, // Pin drive
  output logic                         secondary_data_line_oe,  // Drive en
  input  wire logic                    paired_in_mode, // Core: paired write
  input  wire logic                    paired_out_mode, // Core: paired read
  input  wire logic                    tx_enable,      // Core: drive data
  input  wire logic [`SFP_BYTE_W-1:0]  tx_data,        // Core: next byte
  input  wire logic                    busy,           // Internal cycle
  input  wire logic [`SFP_PROT_W-1:0]  prot_new,       // New size bits
  input  wire logic                    prot_write,     // Size write strobe
  output logic [`SFP_BYTE_W-1:0]       rx_data,        // Received byte
  output logic                         rx_valid,       // Byte pulse
  output logic                         tx_taken,       // tx_data used
  output logic                         frame_start,    // Select fell
  output logic                         frame_end,      // Select rose
  output logic                         selected,       // Select level
  output logic                         paused,         // Pause level
  output logic                         power_active,   // Active power
  output logic                         protect_frozen, // Size locked
  output logic                         protect_size_bit2, // Size bit 2
  output logic                         protect_size_bit1, // Size bit 1
  output logic                         protect_size_bit0  // Size bit 0
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic sfp_pkg::sfp_mode_t link_mode(input logic pin_mode,
                                                   input logic pout_mode);
    if (pin_mode) begin
      return sfp_pkg::SFP_PAIRED_IN;
    end else if (pout_mode) begin
      return sfp_pkg::SFP_PAIRED_OUT;
    end
    return sfp_pkg::SFP_SINGLE;
  endfunction

  function automatic logic [`SFP_CNT_W-1:0] bit_step(
      input sfp_pkg::sfp_mode_t m);
    return (m == sfp_pkg::SFP_SINGLE) ? `SFP_STEP_SINGLE : `SFP_STEP_PAIRED;
  endfunction

  // ----------------------------------------------------------------------
  // Link-domain clears
  // ----------------------------------------------------------------------
  // Frame state ends with select itself, since sclk may stop afterwards
  logic frame_clear;
  logic line_quiet;
  assign frame_clear = select_n | reset;
  assign line_quiet  = select_n | reset | ~pause_n;

  // ----------------------------------------------------------------------
  // Mode and enable synchronisers on sclk
  // ----------------------------------------------------------------------
  logic pin_meta;
  logic pin_sync;
  logic pout_meta;
  logic pout_sync;
  logic txen_meta;
  logic txen_sync;

  always_ff @(posedge sclk or posedge frame_clear) begin
    if (frame_clear) begin
      pin_meta  <= 1'b0;
      pin_sync  <= 1'b0;
      pout_meta <= 1'b0;
      pout_sync <= 1'b0;
      txen_meta <= 1'b0;
      txen_sync <= 1'b0;
    end else begin
      pin_meta  <= paired_in_mode;
      pin_sync  <= pin_meta;
      pout_meta <= paired_out_mode;
      pout_sync <= pout_meta;
      txen_meta <= tx_enable;
      txen_sync <= txen_meta;
    end
  end

  sfp_pkg::sfp_mode_t mode;
  assign mode = link_mode(pin_sync, pout_sync);

  // ----------------------------------------------------------------------
  // Receive shifter, rising edges of sclk
  // ----------------------------------------------------------------------
  logic [`SFP_CNT_W-1:0]  bit_cnt;
  logic [`SFP_BYTE_W-1:0] rx_shift;
  logic [`SFP_BYTE_W-1:0] next_rx_shift;
  logic [`SFP_CNT_W-1:0]  next_bit_cnt;

  always_comb begin
    if (mode == sfp_pkg::SFP_PAIRED_IN) begin
      next_rx_shift = {rx_shift[`SFP_BYTE_W-3:0],
                       secondary_data_line_in,
                       primary_data_line_in};
    end else begin
      next_rx_shift = {rx_shift[`SFP_BYTE_W-2:0],
                       primary_data_line_in};
    end
    next_bit_cnt = bit_cnt + bit_step(mode);
  end

  // Pause holds the bit count and receive shift; sclk and data are ignored here meanwhile
  always_ff @(posedge sclk or posedge frame_clear) begin
    if (frame_clear) begin
      bit_cnt  <= `SFP_CNT_ZERO;
      rx_shift <= `SFP_BYTE_RESET;
    end else if (pause_n) begin
      bit_cnt  <= next_bit_cnt;
      rx_shift <= next_rx_shift;
    end
  end

  // Completed byte held for the clk side; survives deselect
  logic [`SFP_BYTE_W-1:0] rx_hold;
  logic                   rx_toggle;

  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      rx_hold   <= `SFP_BYTE_RESET;
      rx_toggle <= 1'b0;
    end else if (!select_n && pause_n && next_bit_cnt == `SFP_CNT_ZERO) begin
      rx_hold   <= next_rx_shift;
      rx_toggle <= ~rx_toggle;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit shifter, falling edges of sclk
  // ----------------------------------------------------------------------
  logic [`SFP_BYTE_W-1:0] tx_shift;

  always_ff @(negedge sclk or posedge frame_clear) begin
    if (frame_clear) begin
      tx_shift                <= `SFP_BYTE_RESET;
      secondary_data_line_out <= 1'b0;
      primary_data_line_out   <= 1'b0;
    end else if (pause_n) begin
      if (bit_cnt == `SFP_CNT_ZERO) begin
        secondary_data_line_out <= tx_data[`SFP_BYTE_W-1];
        primary_data_line_out   <= tx_data[`SFP_BYTE_W-2];
        if (mode == sfp_pkg::SFP_PAIRED_OUT) begin
          tx_shift <= {tx_data[`SFP_BYTE_W-3:0], 2'h0};
        end else begin
          tx_shift <= {tx_data[`SFP_BYTE_W-2:0], 1'h0};
        end
      end else begin
        secondary_data_line_out <= tx_shift[`SFP_BYTE_W-1];
        primary_data_line_out   <= tx_shift[`SFP_BYTE_W-2];
        if (mode == sfp_pkg::SFP_PAIRED_OUT) begin
          tx_shift <= {tx_shift[`SFP_BYTE_W-3:0], 2'h0};
        end else begin
          tx_shift <= {tx_shift[`SFP_BYTE_W-2:0], 1'h0};
        end
      end
    end
  end

  // Load event for the clk side, so the core can present the next byte
  logic tx_toggle;

  always_ff @(negedge sclk or posedge reset) begin
    if (reset) begin
      tx_toggle <= 1'b0;
    end else if (!select_n && pause_n && txen_sync &&
                 bit_cnt == `SFP_CNT_ZERO) begin
      tx_toggle <= ~tx_toggle;
    end
  end

  // Line direction; released at once on deselect or pause
  always_ff @(negedge sclk or posedge line_quiet) begin
    if (line_quiet) begin
      secondary_data_line_oe <= 1'b0;
      primary_data_line_oe   <= 1'b0;
    end else begin
      secondary_data_line_oe <= txen_sync &&
                                mode != sfp_pkg::SFP_PAIRED_IN;
      primary_data_line_oe   <= txen_sync &&
                                mode == sfp_pkg::SFP_PAIRED_OUT;
    end
  end

  // ----------------------------------------------------------------------
  // Pin and event synchronisers on clk
  // ----------------------------------------------------------------------
  logic sel_meta;
  logic sel_sync;
  logic sel_last;
  logic [2:0] sel_fill;
  logic pause_meta;
  logic pause_sync;
  logic wp_meta;
  logic wp_sync;
  logic rxt_meta;
  logic rxt_sync;
  logic rxt_last;
  logic txt_meta;
  logic txt_sync;
  logic txt_last;

  always_ff @(posedge clk) begin
    if (reset) begin
      sel_meta   <= 1'b0;
      sel_sync   <= 1'b0;
      sel_last   <= 1'b0;
      sel_fill   <= 3'h0;
      pause_meta <= 1'b0;
      pause_sync <= 1'b0;
      wp_meta    <= 1'b0;
      wp_sync    <= 1'b0;
      rxt_meta   <= 1'b0;
      rxt_sync   <= 1'b0;
      rxt_last   <= 1'b0;
      txt_meta   <= 1'b0;
      txt_sync   <= 1'b0;
      txt_last   <= 1'b0;
    end else begin
      sel_meta   <= ~select_n;
      sel_sync   <= sel_meta;
      sel_last   <= sel_sync;
      sel_fill   <= {sel_fill[1:0], 1'b1};
      pause_meta <= ~pause_n;
      pause_sync <= pause_meta;
      wp_meta    <= ~write_protect_n;
      wp_sync    <= wp_meta;
      rxt_meta   <= rx_toggle;
      rxt_sync   <= rxt_meta;
      rxt_last   <= rxt_sync;
      txt_meta   <= tx_toggle;
      txt_sync   <= txt_meta;
      txt_last   <= txt_sync;
    end
  end

  // ----------------------------------------------------------------------
  // Power-up arming: commands wait for a select falling edge
  // ----------------------------------------------------------------------
  // Edge only once the sync stages hold live pin levels
  logic sel_fell;
  assign sel_fell = sel_sync && !sel_last && sel_fill[2];

  logic armed;

  always_ff @(posedge clk) begin
    if (reset) begin
      armed <= 1'b0;
    end else if (sel_fell) begin
      armed <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Frame and byte events toward the core
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_start <= 1'b0;
      frame_end   <= 1'b0;
      selected    <= 1'b0;
      paused      <= 1'b0;
    end else begin
      frame_start <= sel_fell;
      frame_end   <= !sel_sync && sel_last && armed;
      selected    <= sel_sync;
      paused      <= pause_sync && sel_sync;
    end
  end

  // Byte accepted only once armed and only within a frame seen from start
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_data  <= `SFP_BYTE_RESET;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= (rxt_sync != rxt_last) && armed;
      if (rxt_sync != rxt_last) begin
        rx_data <= rx_hold;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      tx_taken <= 1'b0;
    end else begin
      tx_taken <= (txt_sync != txt_last) && armed;
    end
  end

  // ----------------------------------------------------------------------
  // Power mode
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      power_active <= 1'b0;
    end else begin
      power_active <= sel_sync || busy;
    end
  end

  // ----------------------------------------------------------------------
  // Protected area size, frozen while write-protect is low
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      protect_frozen <= 1'b0;
    end else begin
      protect_frozen <= wp_sync;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      {protect_size_bit2, protect_size_bit1, protect_size_bit0}
        <= `SFP_PROT_RESET;
    end else if (prot_write && !wp_sync && !protect_frozen) begin
      {protect_size_bit2, protect_size_bit1, protect_size_bit0}
        <= prot_new;
    end
  end

endmodule

`default_nettype wire

// File: rtl/sfp_defines.svh
// Constants of the serial flash pin interface: widths, counts, reset values.
// Assumes inclusion by bare name from files under rtl/.
//
// Summary of operation
// - Single mode: read data on secondary, falling edges
// - Paired program: secondary is input, rising-edge sampled
// - Host bits on primary captured on rising edge
// - Paired read: primary becomes output, falling edges
// - Deselected: ignore bus, secondary output released
// - Deselected means standby once internal cycle ends
// - Select low enables device, active power mode
// - No command before first select falling edge
// - Pause input suspends transfer, keeps device selected
// - Paused: secondary released, primary and clock ignored
// - Write-protect low freezes protected area size
// - Clock idles low or high; rising edge samples
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH

// ----------------------------------------------------------------------
// Widths and counts
// ----------------------------------------------------------------------
`define SFP_BYTE_W      8
`define SFP_CNT_W       3
`define SFP_PROT_W      3
`define SFP_STEP_SINGLE 3'h1
`define SFP_STEP_PAIRED 3'h2
`define SFP_CNT_ZERO    3'h0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define SFP_PROT_RESET  3'h0
`define SFP_BYTE_RESET  8'h00

`endif

// File: rtl/sfp_pkg.sv
// Types shared by the serial flash pin interface.
// Assumes sfp_defines.svh is not needed here; types only.
package sfp_pkg;

  // ----------------------------------------------------------------------
  // Line usage of the current transfer phase
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SFP_SINGLE,
    SFP_PAIRED_IN,
    SFP_PAIRED_OUT
  } sfp_mode_t;

endpackage

// File: tb/sfp_properties.sv
// Port-level assertions for sfp_pins, bound below.
// Assumes clk and sclk as seen at the sfp_pins ports.
`timescale 1ns/1ps
`default_nettype none
module sfp_properties (
  input wire logic clk,                     // System clock
  input wire logic reset,                   // Sync reset
  input wire logic sclk,                    // Serial clock
  input wire logic select_n,                // Select pin
  input wire logic pause_n,                 // Pause pin
  input wire logic write_protect_n,         // Protect pin
  input wire logic secondary_data_line_out, // Drive value
  input wire logic secondary_data_line_oe,  // Drive enable
  input wire logic primary_data_line_oe,    // Drive enable
  input wire logic busy,                    // Internal cycle
  input wire logic rx_valid,                // Byte pulse
  input wire logic frame_start,             // Select fell
  input wire logic paused,                  // Pause level
  input wire logic power_active,            // Power level
  input wire logic protect_frozen,          // Size locked
  input wire logic protect_size_bit2,       // Size bit
  input wire logic protect_size_bit1,       // Size bit
  input wire logic protect_size_bit0,       // Size bit
  input wire logic tx_taken,                // Byte loaded
  input wire logic frame_end,               // Select rose
  input wire logic selected                 // Select level
);
  logic       armed;
  logic       rise_seen;
  logic       sec_rise;
  logic [2:0] size;
  assign size = {protect_size_bit2, protect_size_bit1, protect_size_bit0};
  always_ff @(posedge clk)
    if (reset) armed <= 1'b0;
    else if (frame_start) armed <= 1'b1;
  // Marks a rising edge seen inside the current frame
  always_ff @(posedge sclk or posedge select_n)
    if (select_n) rise_seen <= 1'b0;
    else rise_seen <= 1'b1;
  always_ff @(posedge sclk) sec_rise <= secondary_data_line_out;

  desel_quiet_a: assert property (@(posedge clk)
    disable iff (reset)
    select_n |-> !secondary_data_line_oe && !primary_data_line_oe)
    else $error("line driven while deselected");
  pause_quiet_a: assert property (@(posedge clk)
    disable iff (reset) !pause_n |-> !secondary_data_line_oe)
    else $error("driven in pause");
  standby_power_a: assert property (@(posedge clk)
    disable iff (reset) (select_n && !busy)[*5] |-> !power_active)
    else $error("no standby");
  busy_power_a: assert property (@(posedge clk)
    disable iff (reset) busy |=> power_active)
    else $error("standby while busy");
  active_power_a: assert property (@(posedge clk)
    disable iff (reset) (!select_n)[*5] |-> power_active)
    else $error("not active");
  sel_level_a: assert property (@(posedge clk)
    disable iff (reset) (!select_n)[*4] |-> selected)
    else $error("select not seen");
  start_pulse_a: assert property (@(posedge clk)
    disable iff (reset) $fell(select_n) |-> ##[1:5] frame_start)
    else $error("no start");
  end_pulse_a: assert property (@(posedge clk)
    disable iff (reset) $rose(select_n) && armed |-> ##[1:5] frame_end)
    else $error("no end");
  armed_rx_a: assert property (@(posedge clk)
    disable iff (reset) rx_valid |-> armed)
    else $error("byte before select fall");
  armed_tx_a: assert property (@(posedge clk)
    disable iff (reset) tx_taken |-> armed)
    else $error("load before select fall");
  pause_level_a: assert property (@(posedge clk)
    disable iff (reset) (!pause_n && !select_n)[*8] |-> ##[0:6] paused)
    else $error("pause not seen");
  freeze_size_a: assert property (@(posedge clk)
    disable iff (reset) protect_frozen |=> $stable(size))
    else $error("size moved");
  frozen_level_a: assert property (@(posedge clk)
    disable iff (reset) (!write_protect_n)[*4] |-> protect_frozen)
    else $error("not frozen");
  fall_shift_a: assert property (@(negedge sclk)
    disable iff (reset) rise_seen && secondary_data_line_oe
    |-> secondary_data_line_out == sec_rise)
    else $error("output moved off falling edge");
  cover property (@(posedge clk) rx_valid);
  cover property (@(posedge clk) paused);
  cover property (@(posedge clk) protect_frozen && busy);
  cover property (@(posedge clk) frame_end);
endmodule
bind sfp_pins sfp_properties i_props (.clk, .reset, .sclk, .select_n,
  .pause_n, .write_protect_n, .secondary_data_line_out,
  .secondary_data_line_oe, .primary_data_line_oe, .busy, .rx_valid,
  .frame_start, .paused, .power_active, .protect_frozen,
  .protect_size_bit2, .protect_size_bit1, .protect_size_bit0,
  .tx_taken, .frame_end, .selected);
`default_nettype wire

// File: tb/sfp_host.sv
// Behavioural SPI host: serial clock, select, pause and host data drive.
// Assumes the bench resolves both data lines from all drive enables.
`timescale 1ns/1ps
`default_nettype none
module sfp_host (
  output logic      sclk,     // Serial clock
  output logic      select_n, // Select, low
  output logic      pause_n,  // Pause, low
  output logic      pri_drv,  // Host primary value
  output logic      sec_drv,  // Host secondary value
  input  wire logic pri_pin,  // Primary level
  input  wire logic sec_pin   // Secondary level
);
  logic cpol;
  initial begin
    cpol = 1'b0;
    sclk = 1'b0;
    select_n = 1'b1;
    pause_n = 1'b1;
    pri_drv = 1'b0;
    sec_drv = 1'b1;
  end
  task automatic sel(input logic v);
    select_n = v;
    #62.5;
  endtask
  task automatic idle(input logic c);
    cpol = c;
    sclk = c;
    #62.5;
  endtask
  // Released lines toggle so a stale level never reads as data
  task automatic byte_x(input logic [7:0] tx, input logic [1:0] m,
                        input int hold, output logic [7:0] rx);
    int n;
    n = (m == 2'd0) ? 8 : 4;
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      #62.5 sclk = 1'b0;
      if (i == hold) begin
        pause_n = 1'b0;
        pri_drv = ~pri_drv;
        #62.5 sclk = 1'b1;
        #62.5 sclk = 1'b0;
        #250 pause_n = 1'b1;
      end
      case (m)
        2'd0: {sec_drv, pri_drv} = {~sec_drv, tx[7 - i]};
        2'd1: {sec_drv, pri_drv} = tx[7 - 2 * i -: 2];
        default: {sec_drv, pri_drv} = ~{sec_drv, pri_drv};
      endcase
      #62.5;
      rx = (m == 2'd2) ? {rx[5:0], sec_pin, pri_pin} : {rx[6:0], sec_pin};
      sclk = 1'b1;
    end
    #62.5 sclk = cpol;
  endtask
endmodule
`default_nettype wire

// File: tb/serial_flash_pin_interface_tb.sv
// Self-checking bench for sfp_pins; the bench plays the command core.
// Assumes sfp_host drives the link side of the pins.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_pin_interface_tb;
  logic       clk, reset, write_protect_n, busy, prot_write;
  logic       paired_in_mode, paired_out_mode, tx_enable;
  logic       sclk, select_n, pause_n, h_pri, h_sec;
  logic       pri_out, pri_oe, sec_out, sec_oe, rx_valid;
  logic [7:0] tx_data, rx_data, last_rx, got, d;
  logic [2:0] prot_new, prot_exp, size;
  logic [1:0] m;
  int         n_fail = 0, checks_done = 0, n_rx = 0;
  wire        pri_pin = pri_oe ? pri_out : h_pri;
  wire        sec_pin = sec_oe ? sec_out : h_sec;

  sfp_pins i_dut (.clk(clk), .reset(reset), .sclk(sclk),
    .select_n(select_n), .pause_n(pause_n),
    .write_protect_n(write_protect_n), .primary_data_line_in(pri_pin),
    .primary_data_line_out(pri_out), .primary_data_line_oe(pri_oe),
    .secondary_data_line_in(sec_pin), .secondary_data_line_out(sec_out),
    .secondary_data_line_oe(sec_oe), .paired_in_mode(paired_in_mode),
    .paired_out_mode(paired_out_mode), .tx_enable(tx_enable),
    .tx_data(tx_data), .busy(busy), .prot_new(prot_new),
    .prot_write(prot_write), .rx_data(rx_data), .rx_valid(rx_valid),
    .tx_taken(), .frame_start(), .frame_end(), .selected(), .paused(),
    .power_active(), .protect_frozen(), .protect_size_bit2(size[2]),
    .protect_size_bit1(size[1]), .protect_size_bit0(size[0]));
  sfp_host i_host (.sclk(sclk), .select_n(select_n), .pause_n(pause_n),
    .pri_drv(h_pri), .sec_drv(h_sec), .pri_pin(pri_pin), .sec_pin(sec_pin));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
    if (rx_valid) begin
      last_rx <= rx_data;
      n_rx <= n_rx + 1;
    end

  function automatic logic [2:0] exp_prot(input logic [2:0] o, n,
                                          input logic wp_n);
    return wp_n ? n : o;
  endfunction
  task automatic check(input logic [7:0] act, exp);
    checks_done++;
    if (act !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic complete_run();
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Command byte first; line mode switches between its 6th and 7th rise
  task automatic frame(input int hold);
    // Host edges kept off the clk edges
    #7;
    i_host.sel(1'b0);
    fork
      i_host.byte_x(8'($urandom), 2'd0, -1, got);
      begin
        repeat (40) @(posedge clk);
        paired_in_mode <= (m == 2'd1);
        paired_out_mode <= (m == 2'd2);
      end
    join
    i_host.byte_x(d, m, hold, got);
    i_host.sel(1'b1);
    @(posedge clk);
    paired_in_mode <= 1'b0;
    paired_out_mode <= 1'b0;
    repeat (8) @(posedge clk);
  endtask

  // ----
  // Scenarios
  // ----
  initial begin
    reset = 1'b1;
    write_protect_n = 1'b1;
    busy = 1'b0;
    prot_write = 1'b0;
    prot_new = 3'h0;
    paired_in_mode = 1'b0;
    paired_out_mode = 1'b0;
    tx_enable = 1'b0;
    tx_data = 8'h00;
    prot_exp = 3'h0;
    void'($urandom(32'hb3db2cba));
    repeat (2) @(posedge clk);
    fork
      i_host.sel(1'b0);
    join_none
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    #7;
    i_host.byte_x(8'ha5, 2'd0, -1, got);
    i_host.sel(1'b1);
    repeat (8) @(posedge clk);
    check(8'(n_rx), 8'h00);
    for (int k = 0; k < 24; k++) begin
      i_host.idle(k[3]);
      @(posedge clk);
      tx_data <= 8'($urandom);
      tx_enable <= 1'b1;
      busy <= 1'($urandom);
      write_protect_n <= 1'($urandom);
      d = (k < 2) ? {8{k[0]}} : 8'($urandom);
      m = 2'(k % 3);
      frame((m == 2'd1) ? int'($urandom_range(3, 0)) : -1);
      if (m != 2'd2)
        check(last_rx, d);
      if (m != 2'd1) check(got, tx_data);
      prot_new <= 3'($urandom);
      prot_write <= 1'b1;
      @(posedge clk);
      prot_write <= 1'b0;
      prot_exp = exp_prot(prot_exp, prot_new, write_protect_n);
      repeat (2) @(posedge clk);
      check({5'h00, size}, {5'h00, prot_exp});
    end
    complete_run();
  end
  initial begin
    #200us;
    n_fail++;
    complete_run();
  end
endmodule
`default_nettype wire
